// file: inc/iptd_pkg.sv
// iptd_pkg: constants, pin and diagnostic carriers, state types of the injector phase timer
// assumes a 40 MHz system clock and an 8 MHz resonator clock sampled as a plain input
//
// Functional notes
// - peak-phase time code is 3 bits: 192 us plus 32 us per step.
// - second-phase time code is 5 bits: 2 us per step, 0 to 62 us.
// - new codes reach the counters only when the second-phase interval ends.
// - group A and group B each keep their own active code latch.
// - written codes go to a holding register at once, applied later.
// - flag peak overtime when peak phase outlasts the programmed peak time.
// - flag peak undertime when peak phase ends before the fixed threshold.
// - overcurrent or overtemperature switches off after an 8 to 18 us filter (no overtemperature input here; overcurrent only, 8 us filter).
// - off-state overvoltage reported after a 3.5 to 4.5 ms filter.
// - high-side feedback acted on only after a 50 to 250 ns filter.
// - reset pin low or undervoltage: switches off, controls high, diagnostics cleared.
package iptd_pkg;
   // clock rates
   localparam int CLK_NS = 25;
   localparam int OSC_KHZ = 8000;
   // programmable timings
   localparam int PEAK_BASE_US = 192;
   localparam int PEAK_STEP_US = 32;
   localparam int SEC_STEP_US = 2;
   localparam int PEAK_BASE_TK = PEAK_BASE_US * OSC_KHZ / 1000;
   localparam int PEAK_STEP_TK = PEAK_STEP_US * OSC_KHZ / 1000;
   localparam int SEC_STEP_TK = SEC_STEP_US * OSC_KHZ / 1000;
   // diagnostic thresholds and filters
   localparam int UNDER_US = 10;
   localparam int OVC_FILT_US = 8;
   localparam int OV_FILT_US = 3500;
   localparam int HS_FILT_NS = 50;
   localparam logic [11:0] UNDER_TK = 12'(UNDER_US * OSC_KHZ / 1000);
   localparam logic [15:0] OVC_FILT_TK = 16'(OVC_FILT_US * OSC_KHZ / 1000);
   localparam logic [15:0] OV_FILT_TK = 16'(OV_FILT_US * OSC_KHZ / 1000);
   localparam logic [15:0] HS_FILT_CYC = 16'((HS_FILT_NS + CLK_NS - 1) / CLK_NS);
   // widths
   localparam int CNT_W = 12;
   localparam int FILT_W = 16;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_PEAK = 2'b01,
      PH_SECOND = 2'b10,
      PH_HOLD = 2'b11
   } iptd_phase_t;

   typedef struct packed {
      logic osc_clk;
      logic [3:0] channel_on_low;
      logic [1:0] peak_reached;
      logic [3:0] overcurrent;
      logic [3:0] off_overvolt;
      logic [1:0] high_side_feedback;
      logic reset_input_low;
      logic supply_low;
   } iptd_pin_t;

   typedef struct packed {
      logic [1:0] peak_over;
      logic [1:0] peak_under;
      logic [3:0] ovc_off;
      logic [3:0] off_ov;
      logic [1:0] hs_fb;
   } iptd_diag_t;

   typedef struct packed {
      logic [FILT_W-1:0] cnt;
      logic qual;
   } iptd_filt_st_t;

   typedef struct packed {
      iptd_pin_t s1;
      iptd_pin_t s2;
      logic osc_prev;
      logic [2:0] pk_hold;
      logic [4:0] sc_hold;
      logic [1:0][2:0] pk_act;
      logic [1:0][4:0] sc_act;
      iptd_phase_t [1:0] ph;
      logic [1:0][CNT_W-1:0] cnt;
      logic [3:0] ovc_st;
      logic [3:0] ov_st;
      iptd_diag_t diag;
      logic [3:0] ls_on;
      logic [1:0] bat_n;
      logic [1:0] bst_n;
      logic sdo_oe;
   } iptd_top_st_t;
endpackage

// file: verilog/iptd_filt.sv
// iptd_filt: level filter, output follows input only after it held steady for limit steps
// assumes cond already synchronised to clk_sys; tick marks one counting step
`timescale 1ns/1ps
`default_nettype none
module iptd_filt (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // control
   input wire logic tick,
   input wire logic clr,
   input wire logic [iptd_pkg::FILT_W-1:0] limit,
   // level in and out
   input wire logic cond,
   output logic qual
);
   iptd_pkg::iptd_filt_st_t st_r;
   iptd_pkg::iptd_filt_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (clr) begin
         st_nxt = '0;
      end else if (cond == st_r.qual) begin
         st_nxt.cnt = '0;
      end else if (tick) begin
         if (st_r.cnt >= limit - 16'h0001) begin
            st_nxt.qual = cond;
            st_nxt.cnt = '0;
         end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign qual = st_r.qual;
endmodule // iptd_filt
`default_nettype wire

// file: verilog/iptd_top.sv
// iptd_top: phase timing, code latching and fault qualification of a quad injector driver
// assumes all pins arrive asynchronously; code and clear strobes come from clk_sys logic
`timescale 1ns/1ps
`default_nettype none
module iptd_top #(
   parameter logic [15:0] OV_FILT_TK = iptd_pkg::OV_FILT_TK
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // device pins
   input wire iptd_pkg::iptd_pin_t pins,
   // serial interface side
   input wire logic code_wr,
   input wire logic [2:0] peak_code,
   input wire logic [4:0] second_code,
   input wire logic diag_clr,
   // switch controls
   output logic [3:0] ls_on,
   output logic [1:0] high_side_ctrl_battery,
   output logic [1:0] high_side_ctrl_boost,
   output logic serial_out_oe,
   // diagnostics
   output iptd_pkg::iptd_diag_t diag,
   output logic [2:0] peak_code_act_a,
   output logic [2:0] peak_code_act_b
);
   iptd_pkg::iptd_top_st_t st_r;
   iptd_pkg::iptd_top_st_t st_nxt;
   logic tick;
   logic force_off;
   logic [3:0] ovc_q;
   logic [3:0] ov_q;
   logic [1:0] fb_q;

   function automatic logic [iptd_pkg::CNT_W-1:0] peak_ticks(input logic [2:0] code);
      peak_ticks = 12'(iptd_pkg::PEAK_BASE_TK) + 12'(iptd_pkg::PEAK_STEP_TK) * {9'h000, code};
   endfunction

   function automatic logic [iptd_pkg::CNT_W-1:0] sec_ticks(input logic [4:0] code);
      sec_ticks = 12'(iptd_pkg::SEC_STEP_TK) * {7'h00, code};
   endfunction

   // resonator step and forced-off condition
   assign tick = st_r.s2.osc_clk & ~st_r.osc_prev;
   assign force_off = ~st_r.s2.reset_input_low | st_r.s2.supply_low;

   // fault filters per channel, feedback filters per group
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         iptd_filt u_ovc (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .tick(tick),
            .clr(force_off),
            .limit(iptd_pkg::OVC_FILT_TK),
            .cond(st_r.s2.overcurrent[gi]),
            .qual(ovc_q[gi])
         );
         iptd_filt u_ov (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .tick(tick),
            .clr(force_off),
            .limit(OV_FILT_TK),
            .cond(st_r.s2.off_overvolt[gi] & ~st_r.ls_on[gi]),
            .qual(ov_q[gi])
         );
      end
      for (gi = 0; gi < 2; gi++) begin : g_grp
         iptd_filt u_fb (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .tick(1'b1),
            .clr(force_off),
            .limit(iptd_pkg::HS_FILT_CYC),
            .cond(st_r.s2.high_side_feedback[gi]),
            .qual(fb_q[gi])
         );
      end
   endgenerate

   always_comb begin
      logic on_g;
      on_g = 1'b0;
      st_nxt = st_r;
      st_nxt.s1 = pins;
      st_nxt.s2 = st_r.s1;
      st_nxt.osc_prev = st_r.s2.osc_clk;
      st_nxt.ovc_st = ovc_q;
      st_nxt.ov_st = ov_q;

      // holding register takes every write at once
      if (code_wr) begin
         st_nxt.pk_hold = peak_code;
         st_nxt.sc_hold = second_code;
      end

      // sticky diagnostics: clear first, events after so a set wins; hs_fb is not sticky and follows its filter
      if (diag_clr) begin
         st_nxt.diag.peak_over = '0;
         st_nxt.diag.peak_under = '0;
         st_nxt.diag.ovc_off = '0;
         st_nxt.diag.off_ov = '0;
      end
      st_nxt.diag.ovc_off = st_nxt.diag.ovc_off | (ovc_q & ~st_r.ovc_st);
      st_nxt.diag.off_ov = st_nxt.diag.off_ov | (ov_q & ~st_r.ov_st);
      st_nxt.diag.hs_fb = fb_q;

      // phase sequence per group
      for (int g = 0; g < 2; g++) begin
         on_g = ~(st_r.s2.channel_on_low[2*g] & st_r.s2.channel_on_low[2*g+1]);
         unique case (st_r.ph[g])
            iptd_pkg::PH_IDLE: begin
               st_nxt.cnt[g] = '0;
               if (on_g) begin
                  st_nxt.ph[g] = iptd_pkg::PH_PEAK;
               end
            end
            iptd_pkg::PH_PEAK: begin
               if (!on_g) begin
                  st_nxt.ph[g] = iptd_pkg::PH_IDLE;
               end else if (st_r.s2.peak_reached[g]) begin
                  if (st_r.cnt[g] < iptd_pkg::UNDER_TK) begin
                     st_nxt.diag.peak_under[g] = 1'b1;
                  end
                  st_nxt.ph[g] = iptd_pkg::PH_SECOND;
                  st_nxt.cnt[g] = '0;
               end else if (st_r.cnt[g] >= peak_ticks(st_r.pk_act[g])) begin
                  st_nxt.diag.peak_over[g] = 1'b1;
                  st_nxt.ph[g] = iptd_pkg::PH_SECOND;
                  st_nxt.cnt[g] = '0;
               end else if (tick) begin
                  st_nxt.cnt[g] = st_r.cnt[g] + 12'h001;
               end
            end
            iptd_pkg::PH_SECOND: begin
               if (st_r.cnt[g] >= sec_ticks(st_r.sc_act[g])) begin
                  st_nxt.pk_act[g] = st_r.pk_hold;
                  st_nxt.sc_act[g] = st_r.sc_hold;
                  st_nxt.ph[g] = on_g ? iptd_pkg::PH_HOLD : iptd_pkg::PH_IDLE;
                  st_nxt.cnt[g] = '0;
               end else if (tick) begin
                  st_nxt.cnt[g] = st_r.cnt[g] + 12'h001;
               end
            end
            iptd_pkg::PH_HOLD: begin
               if (!on_g) begin
                  st_nxt.ph[g] = iptd_pkg::PH_IDLE;
               end
            end
         endcase
      end

      // forced-off state overrides sequence and diagnostics
      if (force_off) begin
         st_nxt.ph[0] = iptd_pkg::PH_IDLE;
         st_nxt.ph[1] = iptd_pkg::PH_IDLE;
         st_nxt.cnt = '0;
         st_nxt.diag = '0;
      end

      // registered switch controls
      for (int c = 0; c < 4; c++) begin
         st_nxt.ls_on[c] = ~st_r.s2.channel_on_low[c] & ~st_nxt.diag.ovc_off[c]
            & (st_nxt.ph[c/2] != iptd_pkg::PH_IDLE) & ~force_off;
      end
      for (int g = 0; g < 2; g++) begin
         st_nxt.bst_n[g] = ~(st_nxt.ph[g] == iptd_pkg::PH_PEAK) | force_off;
         st_nxt.bat_n[g] = ~((st_nxt.ph[g] == iptd_pkg::PH_HOLD) & ~fb_q[g]) | force_off;
      end
      st_nxt.sdo_oe = ~force_off;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
         st_r.bat_n <= 2'h3;
         st_r.bst_n <= 2'h3;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ls_on = st_r.ls_on;
   assign high_side_ctrl_battery = st_r.bat_n;
   assign high_side_ctrl_boost = st_r.bst_n;
   assign serial_out_oe = st_r.sdo_oe;
   assign diag = st_r.diag;
   assign peak_code_act_a = st_r.pk_act[0];
   assign peak_code_act_b = st_r.pk_act[1];
endmodule // iptd_top
`default_nettype wire

// file: test/iptd_top_assertions.sv
// iptd_top_assertions: port checker of the injector phase timer
// assumes counting ticks no faster than 8 MHz, five clk_sys cycles each
`timescale 1ns/1ps
`default_nettype none
module iptd_top_assertions #(
   parameter logic [15:0] OV_FILT_TK = iptd_pkg::OV_FILT_TK
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // watched ports
   input wire iptd_pkg::iptd_pin_t pins,
   input wire logic [3:0] ls_on,
   input wire logic [1:0] high_side_ctrl_battery,
   input wire logic [1:0] high_side_ctrl_boost,
   input wire logic serial_out_oe,
   input wire iptd_pkg::iptd_diag_t diag
);
   // cycles raw overcurrent pin 1 and raw overvoltage pin 3 have stayed high
   logic [15:0] oc_r;
   logic [15:0] ov_r;
   // cycles feedback A has stayed high outside forced-off
   logic [15:0] fb_r;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         oc_r <= 16'h0000;
         ov_r <= 16'h0000;
         fb_r <= 16'h0000;
      end else begin
         oc_r <= pins.overcurrent[1] ? oc_r + 16'h0001 : 16'h0000;
         ov_r <= pins.off_overvolt[3] ? ov_r + 16'h0001 : 16'h0000;
         fb_r <= (pins.high_side_feedback[0] && pins.reset_input_low && !pins.supply_low) ?
            fb_r + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   sequence s_held_off;
      (!pins.reset_input_low || pins.supply_low) [*5];
   endsequence
   sequence s_fb_steady;
      fb_r >= 16'h0009 && pins.high_side_feedback[0] && pins.reset_input_low && !pins.supply_low;
   endsequence
   a_forced_off: assert property (s_held_off |-> ls_on == 4'h0 && diag == '0)
      else $error("switch or flag active while forced off");
   a_ctrl_high: assert property (s_held_off |-> {high_side_ctrl_battery, high_side_ctrl_boost} == 4'hf)
      else $error("high side control low while forced off");
   a_out_float: assert property (s_held_off |-> !serial_out_oe)
      else $error("serial output driven while forced off");
   a_ovc_delay: assert property ($rose(diag.ovc_off[1]) |-> oc_r >= 16'h012c)
      else $error("overcurrent shutdown before its filter time");
   a_ovc_blocks: assert property (diag.ovc_off[1] && $past(diag.ovc_off[1]) |-> !ls_on[1])
      else $error("channel on after overcurrent shutdown");
   a_ov_delay: assert property ($rose(diag.off_ov[3]) |-> ov_r >= OV_FILT_TK * 16'h0005)
      else $error("overvoltage flag before its filter time");
   a_hs_setup: assert property ($rose(diag.hs_fb[0]) |-> $past(pins.high_side_feedback[0], 2) && $past(pins.high_side_feedback[0], 3))
      else $error("feedback accepted from a short pulse");
   a_hs_react: assert property (s_fb_steady |-> diag.hs_fb[0])
      else $error("feedback not taken within its setup time");
endmodule // iptd_top_assertions
bind iptd_top iptd_top_assertions #(.OV_FILT_TK(OV_FILT_TK)) i_iptd_top_assertions (
   .clk_sys(clk_sys), .nrst(nrst), .pins(pins), .ls_on(ls_on),
   .high_side_ctrl_battery(high_side_ctrl_battery), .high_side_ctrl_boost(high_side_ctrl_boost),
   .serial_out_oe(serial_out_oe), .diag(diag));
`default_nettype wire

// file: test/iptd_mcu.sv
// iptd_mcu: controller model that writes time codes and requests channels
// assumes clk_sys; drives just after the falling edge
`timescale 1ns/1ps
`default_nettype none
module iptd_mcu (
   // clock
   input wire logic clk_sys,
   // code writes
   output logic code_wr,
   output logic [2:0] peak_code,
   output logic [4:0] second_code,
   // channel requests
   output logic [3:0] channel_on_low
);
   initial begin
      code_wr = 1'b0;
      peak_code = 3'h0;
      second_code = 5'h00;
      channel_on_low = 4'hf;
   end
   // both codes in one write pulse
   task automatic put_code(input logic [2:0] p, input logic [4:0] s);
      @(negedge clk_sys);
      peak_code = p;
      second_code = s;
      code_wr = 1'b1;
      @(negedge clk_sys);
      code_wr = 1'b0;
   endtask
   // one channel at most, 4 releases all; each level held at least 100 ns
   task automatic request(input int ch);
      @(negedge clk_sys);
      channel_on_low = (ch < 4) ? ~(4'h1 << ch) : 4'hf;
      repeat (4) @(negedge clk_sys);
   endtask
endmodule // iptd_mcu
`default_nettype wire

// file: test/test_injector_phase_timer_diag.sv
// test_injector_phase_timer_diag: scenario bench of the phase timer
// assumes a 5 MHz resonator stand-in and a 20 tick overvoltage filter
`timescale 1ns/1ps
`default_nettype none
module test_injector_phase_timer_diag;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic osc = 1'b0;
   logic [1:0] pk = 2'h0;
   logic [3:0] oc = 4'h0;
   logic [3:0] ov = 4'h0;
   logic [1:0] fb = 2'h0;
   logic rin_n = 1'b1;
   logic sup = 1'b0;
   logic clr = 1'b0;
   logic wr;
   logic [2:0] pc;
   logic [4:0] sc;
   logic [3:0] req;
   logic [3:0] ls_on;
   logic [1:0] bat_n;
   logic [1:0] bst_n;
   logic oe;
   logic [2:0] act_a;
   logic [2:0] act_b;
   iptd_pkg::iptd_pin_t pins;
   iptd_pkg::iptd_diag_t diag;
   int mismatches = 0;
   int compares = 0;
   always #12.5 clk_sys = ~clk_sys;
   always #100 osc = ~osc;
   assign pins = {osc, req, pk, oc, ov, fb, rin_n, sup};
   iptd_mcu i_iptd_mcu (.clk_sys(clk_sys), .code_wr(wr), .peak_code(pc), .second_code(sc),
      .channel_on_low(req));
   iptd_top #(.OV_FILT_TK(16'h0014)) i_iptd_top (.clk_sys(clk_sys), .nrst(nrst), .pins(pins),
      .code_wr(wr), .peak_code(pc), .second_code(sc), .diag_clr(clr), .ls_on(ls_on),
      .high_side_ctrl_battery(bat_n), .high_side_ctrl_boost(bst_n), .serial_out_oe(oe),
      .diag(diag), .peak_code_act_a(act_a), .peak_code_act_b(act_b));
   task automatic w(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // codes held until group A leaves its second phase
   task automatic t_codes;
      i_iptd_mcu.put_code(3'h7, 5'h01);
      i_iptd_mcu.request(0);
      w(40);
      chk(act_a, 3'h0);
      chk({ls_on, bat_n, bst_n}, 8'h1e);
      pk[0] = 1'b1;
      w(20);
      chk(diag.peak_under, 2'h1);
      chk({ls_on, bat_n, bst_n}, 8'h1b);
      chk(act_a, 3'h7);
      chk(act_b, 3'h0);
      i_iptd_mcu.request(4);
      pk[0] = 1'b0;
   endtask
   // group B peak runs out at 1536 ticks
   task automatic t_over;
      i_iptd_mcu.request(2);
      w(12000);
      chk(diag.peak_over, 2'h0);
      w(480);
      chk(diag.peak_over, 2'h2);
      chk(act_b, 3'h7);
      i_iptd_mcu.request(4);
   endtask
   task automatic t_ovc;
      oc = 4'hf;
      w(320);
      oc = 4'h0;
      w(4);
      oc = 4'hf;
      w(320);
      chk(diag.ovc_off, 4'h0);
      w(320);
      chk(diag.ovc_off, 4'hf);
      i_iptd_mcu.request(1);
      w(8);
      chk(ls_on, 4'h0);
      oc = 4'h0;
      i_iptd_mcu.request(4);
      clr = 1'b1;
      w(1);
      clr = 1'b0;
      w(2);
      chk(diag.ovc_off, 4'h0);
   endtask
   task automatic t_ov;
      ov = 4'hf;
      w(120);
      ov = 4'h0;
      w(4);
      ov = 4'hf;
      w(120);
      chk(diag.off_ov, 4'h0);
      w(120);
      chk(diag.off_ov, 4'hf);
      ov = 4'h0;
   endtask
   task automatic t_hs;
      fb[0] = 1'b1;
      w(1);
      fb[0] = 1'b0;
      w(10);
      chk(diag.hs_fb, 2'h0);
      fb[0] = 1'b1;
      w(12);
      chk(diag.hs_fb, 2'h1);
      fb[0] = 1'b0;
   endtask
   // undervoltage, then reset pin
   task automatic t_forced;
      for (int i = 0; i < 2; i++) begin
         fb[1] = 1'b1;
         i_iptd_mcu.request(0);
         w(12);
         chk(diag.hs_fb[1], 1'b1);
         sup = (i == 0);
         rin_n = (i == 0);
         w(6);
         chk(diag, 14'h0000);
         chk({ls_on, bat_n, bst_n, oe}, 9'h01e);
         sup = 1'b0;
         rin_n = 1'b1;
         fb[1] = 1'b0;
         i_iptd_mcu.request(4);
         w(6);
      end
   endtask
   initial begin
      w(10);
      chk({ls_on, bat_n, bst_n, oe, diag}, 23'h078000);
      w(6);
      nrst = 1'b1;
      w(8);
      t_codes;
      t_over;
      t_ovc;
      t_ov;
      t_hs;
      t_forced;
      end_sim;
   end
   initial begin
      #600000;
      mismatches++;
      end_sim;
   end
endmodule // test_injector_phase_timer_diag
`default_nettype wire
